// ==== hdl/ptt_regs.svh ====
// register map, field positions, reset values and counts of the periodic tick timer
// assumes inclusion by bare name from any design file that needs the map
//
// What this block does
// - four-bit interval field picks tick spacing
// - timer runs only while enable bit set
// - busy flag high while control write crosses
// - interrupt enable gates the periodic request
// - flag sets each time interval elapses
// - writing one clears flag, zero keeps it
// - debug halt without run bit freezes timer
// - debug halt with run bit keeps counting
`ifndef PTT_REGS_SVH
`define PTT_REGS_SVH

// register indices; byte address is four times the index
`define PTT_IDX_CONTROL 10'h010
`define PTT_IDX_SYNC_STATUS 10'h011
`define PTT_IDX_IRQ_ENABLE 10'h012
`define PTT_IDX_IRQ_FLAG 10'h013
`define PTT_IDX_DEBUG_CONTROL 10'h015
`define PTT_ADDR_W 12

// field positions
`define PTT_PERIOD_MSB 6
`define PTT_PERIOD_LSB 3
`define PTT_ENABLE_BIT 0
`define PTT_BUSY_BIT 0
`define PTT_IRQ_BIT 0
`define PTT_RUN_IN_DEBUG_HALT_BIT 0
`define PTT_CONTROL_MASK 8'h79

// reset values
`define PTT_CONTROL_RST 8'h00
`define PTT_IRQ_ENABLE_RST 1'b0
`define PTT_IRQ_FLAG_RST 1'b0
`define PTT_DEBUG_RST 1'b0

// interval codes and counter size
`define PTT_PERIOD_OFF 4'h0
`define PTT_PERIOD_RSVD 4'hf
`define PTT_CNT_W 15
`define PTT_CNT_ZERO 15'h0000

`endif

// ==== hdl/ptt_pkg.sv ====
// types shared by the periodic tick timer
// assumes the register map header is included by the modules
package ptt_pkg;
    typedef logic [3:0] ptt_period_t;
    typedef enum logic [1:0] {PTT_SYNC_IDLE, PTT_SYNC_WAIT1, PTT_SYNC_WAIT2} ptt_sync_state_t;
endpackage

// ==== hdl/ptt_core_if.sv ====
// link between the register front end and the tick counter core
// assumes both ends run on clk_sys
`timescale 1ns/1ps
interface ptt_core_if;
    import ptt_pkg::*;
    logic step;
    logic enable;
    ptt_period_t period;
    logic tick;
    logic [14:0] count;
    modport ctrl (output step, output enable, output period, input tick, input count);
    modport core (input step, input enable, input period, output tick, output count);
endinterface

// ==== hdl/ptt_tick_core.sv ====
// tick counter core: counts counter-clock steps and pulses tick at the chosen interval
// assumes step is a one-cycle pulse per counter-clock edge, already gated by halt
`timescale 1ns/1ps
`include "ptt_regs.svh"
module ptt_tick_core
    import ptt_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // control and tick
    ptt_core_if.core bus
);

    logic [`PTT_CNT_W-1:0] cnt_reg;
    logic [`PTT_CNT_W-1:0] cnt_next;
    logic [`PTT_CNT_W-1:0] mask;
    logic tick_reg;
    logic tick_next;
    logic period_valid;

    ////////////////////////////////////////////////////////////////////////////////
    // interval mask: code n covers n+1 low counter bits, so code 1 gives 4 steps
    genvar gi;
    generate
        for (gi = 0; gi < `PTT_CNT_W; gi++)
        begin : g_mask
            assign mask[gi] = (4'(gi) <= bus.period);
        end
    endgenerate

    assign period_valid = (bus.period != `PTT_PERIOD_OFF) && (bus.period != `PTT_PERIOD_RSVD);

    ////////////////////////////////////////////////////////////////////////////////
    // counter next value and tick decision
    always_comb
    begin
        cnt_next = cnt_reg;
        tick_next = 1'b0;
        if (!bus.enable)
        begin
            cnt_next = `PTT_CNT_ZERO;
        end
        else if (bus.step)
        begin
            cnt_next = cnt_reg + 15'h0001;
            tick_next = period_valid && ((cnt_reg & mask) == mask);
        end
    end

    // counter state; wraps freely so every interval stays a power of two
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            cnt_reg <= `PTT_CNT_ZERO;
        end
        else
        begin
            cnt_reg <= cnt_next;
        end
    end

    // tick pulse register
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            tick_reg <= 1'b0;
        end
        else
        begin
            tick_reg <= tick_next;
        end
    end

    assign bus.tick = tick_reg;
    assign bus.count = cnt_reg;

endmodule

// ==== hdl/ptt_timer.sv ====
// periodic tick timer top: apb register file, control crossing, flag and interrupt
// assumes counter clock level arrives on rtc_clk_in synchronous to clk_sys and far slower
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "ptt_regs.svh"
module ptt_timer
    import ptt_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PTT_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // counter clock and debug
    input wire logic rtc_clk_in,
    input wire logic dbg_halt,
    // interrupt
    output logic irq
);

    ptt_core_if core_bus ();

    logic setup;
    logic access_done;
    logic wr_commit;
    logic sel_ctrl;
    logic sel_stat;
    logic sel_ien;
    logic sel_flag;
    logic sel_dbg;
    logic addr_hit;
    logic [7:0] rd_byte;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [7:0] ctrl_reg;
    logic irq_en_reg;
    logic dbg_run_reg;
    logic flag_reg;
    logic flag_next;
    logic irq_reg;
    logic rtc_prev_reg;
    logic rtc_edge;
    logic wr_ctrl;
    logic busy;
    logic run;
    ptt_sync_state_t sync_reg;
    ptt_sync_state_t sync_next;
    ptt_period_t period_live_reg;
    logic en_live_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // apb address decode
    assign sel_ctrl = (paddr == {`PTT_IDX_CONTROL, 2'b00});
    assign sel_stat = (paddr == {`PTT_IDX_SYNC_STATUS, 2'b00});
    assign sel_ien = (paddr == {`PTT_IDX_IRQ_ENABLE, 2'b00});
    assign sel_flag = (paddr == {`PTT_IDX_IRQ_FLAG, 2'b00});
    assign sel_dbg = (paddr == {`PTT_IDX_DEBUG_CONTROL, 2'b00});
    assign addr_hit = sel_ctrl | sel_stat | sel_ien | sel_flag | sel_dbg;

    // phases: answer comes in the first access cycle, so no wait states
    assign setup = psel & ~penable;
    assign access_done = psel & penable & pready_reg;
    assign wr_commit = access_done & pwrite & ~pslverr_reg;
    assign wr_ctrl = wr_commit & sel_ctrl;

    // read mux; unmapped reads give zero with an error
    always_comb
    begin
        rd_byte = 8'h00;
        if (sel_ctrl)
        begin
            rd_byte = ctrl_reg;
        end
        else if (sel_stat)
        begin
            rd_byte[`PTT_BUSY_BIT] = busy;
        end
        else if (sel_ien)
        begin
            rd_byte[`PTT_IRQ_BIT] = irq_en_reg;
        end
        else if (sel_flag)
        begin
            rd_byte[`PTT_IRQ_BIT] = flag_reg;
        end
        else if (sel_dbg)
        begin
            rd_byte[`PTT_RUN_IN_DEBUG_HALT_BIT] = dbg_run_reg;
        end
    end

    // ready strobe: high exactly in the access cycle after a setup
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            pready_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= setup;
        end
    end

    // read data and error captured during setup, held through access
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else if (setup)
        begin
            prdata_reg <= {24'h00_0000, rd_byte};
            pslverr_reg <= ~addr_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // software-written registers
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ctrl_reg <= `PTT_CONTROL_RST;
        end
        else if (wr_ctrl)
        begin
            ctrl_reg <= pwdata[7:0] & `PTT_CONTROL_MASK; // reserved bits read zero
        end
    end

    // interrupt enable and debug-run bits
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            irq_en_reg <= `PTT_IRQ_ENABLE_RST;
            dbg_run_reg <= `PTT_DEBUG_RST;
        end
        else
        begin
            if (wr_commit && sel_ien)
            begin
                irq_en_reg <= pwdata[`PTT_IRQ_BIT];
            end
            if (wr_commit && sel_dbg)
            begin
                dbg_run_reg <= pwdata[`PTT_RUN_IN_DEBUG_HALT_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // counter clock edge detect; the pin is already synchronous to clk_sys
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            rtc_prev_reg <= 1'b0;
        end
        else
        begin
            rtc_prev_reg <= rtc_clk_in;
        end
    end

    assign rtc_edge = rtc_clk_in & ~rtc_prev_reg;

    // control crossing: new value takes effect after two counter-clock edges
    always_comb
    begin
        sync_next = sync_reg;
        unique case (sync_reg)
            PTT_SYNC_IDLE:
            begin
                sync_next = PTT_SYNC_IDLE;
            end
            PTT_SYNC_WAIT1:
            begin
                if (rtc_edge)
                begin
                    sync_next = PTT_SYNC_WAIT2;
                end
            end
            PTT_SYNC_WAIT2:
            begin
                if (rtc_edge)
                begin
                    sync_next = PTT_SYNC_IDLE;
                end
            end
            default:
            begin
                sync_next = PTT_SYNC_IDLE;
            end
        endcase
        // a write while busy restarts the crossing rather than being dropped
        if (wr_ctrl)
        begin
            sync_next = PTT_SYNC_WAIT1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            sync_reg <= PTT_SYNC_IDLE;
        end
        else
        begin
            sync_reg <= sync_next;
        end
    end

    assign busy = (sync_reg != PTT_SYNC_IDLE);

    // live copy seen by the counter, loaded when the crossing completes
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            period_live_reg <= `PTT_PERIOD_OFF;
            en_live_reg <= 1'b0;
        end
        else if (sync_reg == PTT_SYNC_WAIT2 && rtc_edge && !wr_ctrl)
        begin
            period_live_reg <= ctrl_reg[`PTT_PERIOD_MSB:`PTT_PERIOD_LSB];
            en_live_reg <= ctrl_reg[`PTT_ENABLE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // counter core hookup; halt without run bit swallows counter edges
    assign run = en_live_reg & (dbg_run_reg | ~dbg_halt);
    assign core_bus.step = rtc_edge & run;
    assign core_bus.enable = en_live_reg;
    assign core_bus.period = period_live_reg;

    ptt_tick_core i_ptt_tick_core (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .bus(core_bus.core)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // periodic flag: a tick in the same cycle as a clear wins
    always_comb
    begin
        flag_next = flag_reg;
        if (wr_commit && sel_flag && pwdata[`PTT_IRQ_BIT])
        begin
            flag_next = 1'b0;
        end
        if (core_bus.tick)
        begin
            flag_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            flag_reg <= `PTT_IRQ_FLAG_RST;
        end
        else
        begin
            flag_reg <= flag_next;
        end
    end

    // interrupt level, registered so the pin is glitch free
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= flag_reg & irq_en_reg;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    busy_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_ctrl |=> busy)
        else $error("busy not raised after control write");

    busy_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sync_reg == PTT_SYNC_WAIT2 && rtc_edge && !wr_ctrl) |=>
        !busy && (en_live_reg == $past(ctrl_reg[`PTT_ENABLE_BIT])))
        else $error("crossing did not complete");

    flag_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        core_bus.tick |=> flag_reg)
        else $error("flag missed a tick");

    flag_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (wr_commit && sel_flag && pwdata[`PTT_IRQ_BIT] && !core_bus.tick) |=> !flag_reg)
        else $error("flag not cleared by one");

    flag_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (flag_reg && !(wr_commit && sel_flag && pwdata[`PTT_IRQ_BIT])) |=> flag_reg)
        else $error("flag dropped without clear");

    irq_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ##1 (irq == ($past(flag_reg) && $past(irq_en_reg))))
        else $error("irq not flag and enable");

    halt_freeze_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (dbg_halt && !dbg_run_reg && en_live_reg) [*2] |=> $stable(core_bus.count))
        else $error("counter moved in debug halt");

    halt_run_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (dbg_halt && dbg_run_reg && en_live_reg && rtc_edge) |=> (core_bus.count != $past(core_bus.count)))
        else $error("counter stalled with run bit");

    disabled_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !en_live_reg |=> (core_bus.count == `PTT_CNT_ZERO) && !core_bus.tick)
        else $error("counter active while disabled");

    off_code_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (period_live_reg == `PTT_PERIOD_OFF || period_live_reg == `PTT_PERIOD_RSVD) |=> !core_bus.tick)
        else $error("tick with off or reserved code");

    irq_block_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !irq_en_reg [*2] |-> !irq)
        else $error("irq raised while disabled");

    apb_ready_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        setup |=> pready ##1 !pready)
        else $error("ready not one cycle after setup");

endmodule

// ==== verif/tb_top.sv ====
// self-checking bench for the periodic tick timer: apb tasks, counter-clock steps, irq watch
// assumes ptt_timer and the register map header are on the compile path; one clock, clk_sys
`timescale 1ns/1ps
`include "ptt_regs.svh"
module tb_top;

////////////////////////////////////////////////////////////////////////////////
// signals and the design
logic clk_sys, rst_n, psel, penable, pwrite, rtc_clk_in, dbg_halt;
logic [`PTT_ADDR_W-1:0] paddr;
logic [31:0] pwdata, prdata, rdata;
logic pready, pslverr, irq, err;
int fails, check_count, n;
localparam logic [11:0] A_CTRL = {`PTT_IDX_CONTROL, 2'b00};
localparam logic [11:0] A_STAT = {`PTT_IDX_SYNC_STATUS, 2'b00};
localparam logic [11:0] A_IEN = {`PTT_IDX_IRQ_ENABLE, 2'b00};
localparam logic [11:0] A_FLAG = {`PTT_IDX_IRQ_FLAG, 2'b00};
localparam logic [11:0] A_DBG = {`PTT_IDX_DEBUG_CONTROL, 2'b00};
localparam logic [11:0] A_BAD = 12'h050;

ptt_timer i_ptt_timer (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rtc_clk_in(rtc_clk_in), .dbg_halt(dbg_halt), .irq(irq)
);

// free-running 100 MHz system clock
initial
begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
end

////////////////////////////////////////////////////////////////////////////////
// reporting
task automatic wrap_up();
    if (fails == 0 && check_count > 0)
        $display("Simulation passed");
    else
        $display("Simulation failed");
    $finish;
endtask

task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
        fails++;
        $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
endtask

////////////////////////////////////////////////////////////////////////////////
// apb master: request held until pready is sampled high, released at that edge
task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do
    begin
        @(posedge clk_sys);
        k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1)
    begin
        fails++;
        wrap_up();
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask

task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
endtask

task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    check(rdata, exp);
endtask

////////////////////////////////////////////////////////////////////////////////
// counter clock: one rising level per step, long enough for tick, flag and irq to land
task automatic steps(input int cnt);
    repeat (cnt)
    begin
        @(posedge clk_sys);
        rtc_clk_in <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rtc_clk_in <= 1'b0;
        repeat (4) @(posedge clk_sys);
    end
endtask

// steps until irq is seen, bounded; count returned in n
task automatic count_ticks(input int lim);
    n = 0;
    do
    begin
        steps(1);
        n++;
    end
    while (irq !== 1'b1 && n < lim);
endtask

// control write, busy while crossing, clear after two counter edges
task automatic set_ctrl(input logic [7:0] v);
    wr(A_CTRL, {24'h0, v});
    rd(A_STAT, 32'h1);
    steps(2);
    rd(A_STAT, 32'h0);
endtask

////////////////////////////////////////////////////////////////////////////////
// watchdog: a hang counts as a mismatch
initial
begin
    repeat (90000) @(posedge clk_sys);
    fails++;
    wrap_up();
end

// main sequence
initial
begin
    fails = 0;
    check_count = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    rtc_clk_in = 1'b0;
    dbg_halt = 1'b0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    // reset values, read-only status, refused address
    rd(A_CTRL, 32'h0);
    rd(A_STAT, 32'h0);
    rd(A_IEN, 32'h0);
    rd(A_FLAG, 32'h0);
    rd(A_DBG, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(A_STAT, 32'h0000_00ff);
    rd(A_STAT, 32'h0);
    xfer(1'b0, A_BAD, 32'h0000_0000);
    check({31'h0, err}, 32'h1);
    check(rdata, 32'h0);
    // interval codes 1..5: spacing between two ticks is 2^(code+1) counter cycles
    wr(A_IEN, 32'h1);
    for (int c = 1; c <= 5; c++)
    begin
        set_ctrl({1'b0, 4'(c), 3'b000} | 8'h01);
        rd(A_CTRL, {25'h0, 4'(c), 3'b001});
        count_ticks(300);
        rd(A_FLAG, 32'h1);
        if (c == 1)
        begin
            // writing zero keeps the flag; enable gates the line
            wr(A_FLAG, 32'h0);
            rd(A_FLAG, 32'h1);
            check({31'h0, irq}, 32'h1);
            wr(A_IEN, 32'h0);
            repeat (3) @(posedge clk_sys);
            check({31'h0, irq}, 32'h0);
            wr(A_IEN, 32'h1);
            repeat (3) @(posedge clk_sys);
            check({31'h0, irq}, 32'h1);
        end
        wr(A_FLAG, 32'h1);
        rd(A_FLAG, 32'h0);
        check({31'h0, irq}, 32'h0);
        count_ticks(300);
        check(32'(n), 32'(2 << c));
        wr(A_FLAG, 32'h1);
    end
    // halt with run bit clear drops counter edges; counter value is kept
    dbg_halt <= 1'b1;
    steps(80);
    check({31'h0, irq}, 32'h0);
    dbg_halt <= 1'b0;
    count_ticks(300);
    check(32'(n), 32'd64);
    // halt with run bit set keeps counting
    wr(A_DBG, 32'h1);
    rd(A_DBG, 32'h1);
    wr(A_FLAG, 32'h1);
    dbg_halt <= 1'b1;
    count_ticks(300);
    check(32'(n), 32'd64);
    dbg_halt <= 1'b0;
    // off and reserved codes give no tick
    for (int k = 0; k < 2; k++)
    begin
        set_ctrl(k == 0 ? 8'h01 : 8'h79);
        wr(A_FLAG, 32'h1);
        steps(80);
        check({31'h0, irq}, 32'h0);
    end
    // disabled timer gives no tick, re-enabled timer ticks again
    set_ctrl(8'h08);
    wr(A_FLAG, 32'h1);
    steps(20);
    check({31'h0, irq}, 32'h0);
    set_ctrl(8'h09);
    count_ticks(12);
    check({31'h0, irq}, 32'h1);
    wrap_up();
end

endmodule
